// *** design/plt_lane_mem.sv ***
// One lane of the table: all banks, one write port, a pixel and a host read port.
// Assumes writes come from the control logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module plt_lane_mem import plt_pkg::*; #(
	parameter int BANKS = PLT_BANKS,
	parameter int DEPTH = PLT_DEPTH,
	parameter int WIDTH = PLT_PIX_W
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic en_in,
	input wire logic we_in,
	input wire logic [$clog2(BANKS)-1:0] wr_bank_in,
	input wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic [$clog2(BANKS)-1:0] rd_bank_in,
	input wire logic [$clog2(DEPTH)-1:0] pix_addr_in,
	input wire logic [$clog2(DEPTH)-1:0] host_addr_in,
	output logic [WIDTH-1:0] pix_data_out,
	output logic [WIDTH-1:0] host_data_out
);
	typedef struct packed {
		logic [BANKS*DEPTH-1:0][WIDTH-1:0] mem;
	} plt_mem_s;

	plt_mem_s st_q;
	plt_mem_s st_d;

	always_comb begin
		st_d = st_q;
		if (we_in) begin
			st_d.mem[{wr_bank_in, wr_addr_in}] = wr_data_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q <= '0;
		end else if (en_in) begin
			st_q <= st_d;
		end
	end

	// Same bank feeds the pixels and the host
	assign pix_data_out = st_q.mem[{rd_bank_in, pix_addr_in}];
	assign host_data_out = st_q.mem[{rd_bank_in, host_addr_in}];
endmodule
`default_nettype wire

// *** design/plt_pix_stage.sv ***
// Output register of one pixel lane: bypass or table value.
// Assumes the table value is already looked up from this lane's pixel.
`timescale 1ns/1ps
`default_nettype none
module plt_pix_stage import plt_pkg::*; #(
	parameter int WIDTH = PLT_PIX_W
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic en_in,
	input wire logic load_in,
	input wire logic insert_in,
	input wire logic [WIDTH-1:0] pix_in,
	input wire logic [WIDTH-1:0] table_in,
	output logic [WIDTH-1:0] pix_out
);
	typedef struct packed {
		logic [WIDTH-1:0] pix;
	} plt_stage_s;

	plt_stage_s st_q;
	plt_stage_s st_d;

	always_comb begin
		st_d = st_q;
		if (load_in) begin
			st_d.pix = insert_in ? table_in : pix_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q <= '0;
		end else if (en_in) begin
			st_q <= st_d;
		end
	end

	assign pix_out = st_q.pix;
endmodule
`default_nettype wire

// *** design/plt_pkg.sv ***
// Constants for the pixel lookup table: control word layout, reset values, sizes.
// Assumes one 32-bit control register on a plain strobe bus; pixels are 8 bits per lane.
// Functional notes
// - Table-insert bit 0 bypasses the table, 1 sends pixels through it.
// - Host data field sits in control bits 7..0; table reached only through it.
// - Strobe write 1 copies data field into table at bank, lane, address.
// - In mode 0, reading data field returns the stored table entry.
// - Host address field is bits 23..16; address is table input value.
// - Bank field for host access is bits 25..24.
// - Lane field for host access is bits 29..28.
// - Bank field also selects the bank that image data passes through.
// - Mode 1: data field is plain storage; mode 0: strobe does nothing.
// - Access-enable bit 0 denies host table access; 1 permits it.
package plt_pkg;
	localparam int PLT_LANES = 4;
	localparam int PLT_BANKS = 4;
	localparam int PLT_PIX_W = 8;
	localparam int PLT_DEPTH = 256;
	localparam int PLT_REG_AW = 8;
	localparam logic [PLT_REG_AW-1:0] PLT_CTRL_OFS = 8'h00;
	localparam int PLT_DATA_LSB = 0;
	localparam int PLT_INSERT_BIT = 15;
	localparam int PLT_ADDR_LSB = 16;
	localparam int PLT_BANK_LSB = 24;
	localparam int PLT_WSEL_BIT = 27;
	localparam int PLT_LANE_LSB = 28;
	localparam int PLT_STROBE_BIT = 30;
	localparam int PLT_ACCESS_BIT = 31;
	localparam logic [7:0] PLT_DATA_RST = 8'h00;
	localparam logic [7:0] PLT_ADDR_RST = 8'h00;
	localparam logic [1:0] PLT_SEL_RST = 2'h0;
	localparam logic PLT_BIT_RST = 1'b0;
	localparam logic [31:0] PLT_WORD_ZERO = 32'h0000_0000;
endpackage

// *** design/plt_top.sv ***
// Banked, multi-lane pixel lookup table with its indirect host control register.
// Assumes pixels arrive from logic on CLK_SYS_IN; host uses the plain strobe bus.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module plt_top import plt_pkg::*; #(
	parameter int LANES = PLT_LANES,
	parameter int BANKS = PLT_BANKS,
	parameter int DEPTH = PLT_DEPTH
) (
	input wire logic CLK_SYS_IN,
	input wire logic SYS_RST_IN,
	input wire logic CLK_EN_IN,
	input wire logic [PLT_REG_AW-1:0] REG_ADDR_IN,
	input wire logic [31:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	output logic [31:0] REG_RDATA_OUT,
	input wire logic PIX_VALID_IN,
	input wire logic [LANES*PLT_PIX_W-1:0] PIX_DATA_IN,
	output logic PIX_VALID_OUT,
	output logic [LANES*PLT_PIX_W-1:0] PIX_DATA_OUT
);
	localparam int BW = $clog2(BANKS);
	localparam int AW = $clog2(DEPTH);
	localparam int LW = $clog2(LANES);

	typedef struct packed {
		logic [PLT_PIX_W-1:0] data;
		logic insert;
		logic [AW-1:0] addr;
		logic [BW-1:0] bank;
		logic wsel;
		logic [LW-1:0] lane;
		logic access;
		logic [31:0] rdata;
		logic pix_valid;
	} plt_ctl_s;

	plt_ctl_s st_q;
	plt_ctl_s st_d;

	logic ctrl_hit;
	logic ctrl_wr;
	logic ctrl_rd;
	logic mem_we;
	logic [LW-1:0] wr_lane;
	logic [LANES-1:0][PLT_PIX_W-1:0] pix_rd;
	logic [LANES-1:0][PLT_PIX_W-1:0] host_rd;
	logic [PLT_PIX_W-1:0] host_sel;

	assign ctrl_hit = (REG_ADDR_IN == PLT_CTRL_OFS);
	assign ctrl_wr = REG_WR_IN && ctrl_hit;
	assign ctrl_rd = REG_RD_IN && ctrl_hit;
	assign wr_lane = REG_WDATA_IN[PLT_LANE_LSB +: LW];
	assign host_sel = host_rd[st_q.lane];

	// Strobe only acts with access on and write mode set in the same word
	assign mem_we = ctrl_wr && REG_WDATA_IN[PLT_STROBE_BIT] && REG_WDATA_IN[PLT_ACCESS_BIT]
		&& REG_WDATA_IN[PLT_WSEL_BIT];

	always_comb begin
		st_d = st_q;
		st_d.rdata = PLT_WORD_ZERO;
		st_d.pix_valid = PIX_VALID_IN;
		if (ctrl_wr) begin
			st_d.insert = REG_WDATA_IN[PLT_INSERT_BIT];
			st_d.addr = REG_WDATA_IN[PLT_ADDR_LSB +: AW];
			st_d.bank = REG_WDATA_IN[PLT_BANK_LSB +: BW];
			st_d.wsel = REG_WDATA_IN[PLT_WSEL_BIT];
			st_d.lane = wr_lane;
			st_d.access = REG_WDATA_IN[PLT_ACCESS_BIT];
			// Data field is read-only while mode 0 is being written
			if (REG_WDATA_IN[PLT_WSEL_BIT]) begin
				st_d.data = REG_WDATA_IN[PLT_DATA_LSB +: PLT_PIX_W];
			end
		end
		if (ctrl_rd) begin
			if (!st_q.wsel && st_q.access) begin
				st_d.rdata[PLT_DATA_LSB +: PLT_PIX_W] = host_sel;
			end else begin
				st_d.rdata[PLT_DATA_LSB +: PLT_PIX_W] = st_q.data;
			end
			st_d.rdata[PLT_INSERT_BIT] = st_q.insert;
			st_d.rdata[PLT_ADDR_LSB +: AW] = st_q.addr;
			st_d.rdata[PLT_BANK_LSB +: BW] = st_q.bank;
			st_d.rdata[PLT_WSEL_BIT] = st_q.wsel;
			st_d.rdata[PLT_LANE_LSB +: LW] = st_q.lane;
			st_d.rdata[PLT_ACCESS_BIT] = st_q.access;
		end
	end

	always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			st_q.data <= PLT_DATA_RST;
			st_q.insert <= PLT_BIT_RST;
			st_q.addr <= PLT_ADDR_RST;
			st_q.bank <= PLT_SEL_RST;
			st_q.wsel <= PLT_BIT_RST;
			st_q.lane <= PLT_SEL_RST;
			st_q.access <= PLT_BIT_RST;
			st_q.rdata <= PLT_WORD_ZERO;
			st_q.pix_valid <= PLT_BIT_RST;
		end else if (CLK_EN_IN) begin
			st_q <= st_d;
		end
	end

	assign REG_RDATA_OUT = st_q.rdata;
	assign PIX_VALID_OUT = st_q.pix_valid;

	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			plt_lane_mem #(
				.BANKS(BANKS),
				.DEPTH(DEPTH),
				.WIDTH(PLT_PIX_W)
			) u_mem (
				.clk_in(CLK_SYS_IN),
				.rst_in(SYS_RST_IN),
				.en_in(CLK_EN_IN),
				.we_in(mem_we && (wr_lane == LW'(g))),
				.wr_bank_in(REG_WDATA_IN[PLT_BANK_LSB +: BW]),
				.wr_addr_in(REG_WDATA_IN[PLT_ADDR_LSB +: AW]),
				.wr_data_in(REG_WDATA_IN[PLT_DATA_LSB +: PLT_PIX_W]),
				.rd_bank_in(st_q.bank),
				.pix_addr_in(PIX_DATA_IN[g*PLT_PIX_W +: PLT_PIX_W]),
				.host_addr_in(st_q.addr),
				.pix_data_out(pix_rd[g]),
				.host_data_out(host_rd[g])
			);
			// Output only moves on valid pixels, so idle cycles keep the last value
			plt_pix_stage #(
				.WIDTH(PLT_PIX_W)
			) u_stage (
				.clk_in(CLK_SYS_IN),
				.rst_in(SYS_RST_IN),
				.en_in(CLK_EN_IN),
				.load_in(PIX_VALID_IN),
				.insert_in(st_q.insert),
				.pix_in(PIX_DATA_IN[g*PLT_PIX_W +: PLT_PIX_W]),
				.table_in(pix_rd[g]),
				.pix_out(PIX_DATA_OUT[g*PLT_PIX_W +: PLT_PIX_W])
			);
		end
	endgenerate

	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (SYS_RST_IN);

	a_bypass_path: assert property (
		CLK_EN_IN && PIX_VALID_IN && !st_q.insert |=> PIX_DATA_OUT == $past(PIX_DATA_IN))
		else $error("bypassed pixel not passed unchanged");

	a_lookup_path: assert property (
		CLK_EN_IN && PIX_VALID_IN && st_q.insert |=> PIX_DATA_OUT[PLT_PIX_W-1:0] == $past(pix_rd[0]))
		else $error("lane 0 pixel not replaced by table value");

	a_hold_read: assert property (
		CLK_EN_IN && ctrl_rd && st_q.wsel |=> REG_RDATA_OUT[PLT_PIX_W-1:0] == $past(st_q.data))
		else $error("held data field not returned");

	a_strobe_write: assert property (
		CLK_EN_IN && mem_we |=> host_sel == $past(REG_WDATA_IN[PLT_PIX_W-1:0]))
		else $error("strobe did not store data at selected location");

	a_table_read: assert property (
		CLK_EN_IN && ctrl_rd && !st_q.wsel && st_q.access
		|=> REG_RDATA_OUT[PLT_PIX_W-1:0] == $past(host_sel))
		else $error("mode 0 read did not return table entry");

	// Watches lane 0 storage itself, so a broken strobe gate is caught for lane 0 writes only
	a_access_deny: assert property (
		CLK_EN_IN && ctrl_wr && !REG_WDATA_IN[PLT_ACCESS_BIT] |=> $stable(g_lane[0].u_mem.st_q))
		else $error("table written with host access off");

	a_mode0_quiet: assert property (
		CLK_EN_IN && ctrl_wr && !REG_WDATA_IN[PLT_WSEL_BIT] |-> !mem_we ##1 $stable(st_q.data))
		else $error("mode 0 write changed table or data field");

	a_field_readback: assert property (
		CLK_EN_IN && ctrl_rd |=> REG_RDATA_OUT[23:16] == $past(st_q.addr)
		&& REG_RDATA_OUT[25:24] == $past(st_q.bank) && REG_RDATA_OUT[29:28] == $past(st_q.lane))
		else $error("selection fields not read back");

	a_bank_follow: assert property (
		CLK_EN_IN && ctrl_wr |=> st_q.bank == $past(REG_WDATA_IN[25:24]))
		else $error("bank field not taken from bits 25..24");

	a_rdata_idle: assert property (
		CLK_EN_IN && !ctrl_rd |=> REG_RDATA_OUT == 32'h0000_0000)
		else $error("read data present without a read");
endmodule
`default_nettype wire

// *** verif/plt_pix_src.sv ***
// Camera-side pixel source model facing the lookup table.
// Assumes the bench calls send from its main sequence, one pixel at a time.
`timescale 1ns/1ps
`default_nettype none
module plt_pix_src (
	input wire logic clk_in,
	output logic valid_out,
	output logic [31:0] data_out
);
	initial begin
		valid_out = 1'b0;
		data_out = 32'h0000_0000;
	end
	// Idle bus shows the inverse of the last pixel, so a stale copy cannot pass
	task automatic send(input logic [31:0] pix);
		@(posedge clk_in);
		valid_out <= 1'b1;
		data_out <= pix;
		@(posedge clk_in);
		valid_out <= 1'b0;
		data_out <= ~pix;
	endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for plt_top: host table access and the pixel path.
// Assumes plt_pix_src drives the camera side; clock enable is high except in one test.
`timescale 1ns/1ps
`default_nettype none
module testbench import plt_pkg::*;;
	logic clk, rst, wr, rd, pvalid, ovalid, cen;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, pdata, odata;
	int n_fail, n_checks, cyc;

	plt_top dut_u (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .CLK_EN_IN(cen),
		.REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
		.REG_RDATA_OUT(rdata), .PIX_VALID_IN(pvalid), .PIX_DATA_IN(pdata),
		.PIX_VALID_OUT(ovalid), .PIX_DATA_OUT(odata));
	plt_pix_src src_u (.clk_in(clk), .valid_out(pvalid), .data_out(pdata));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	function automatic logic [31:0] mk(input logic acc, input logic stb, input logic [1:0] ln,
		input logic ws, input logic [1:0] bk, input logic [7:0] a, input logic ins,
		input logic [7:0] d);
		return {acc, stb, ln, ws, 1'b0, bk, a, ins, 7'h00, d};
	endfunction

	// Distinct entry per bank, lane and low address nibble
	function automatic logic [7:0] ent(input int l, input int b, input logic [7:0] a);
		return {b[1:0], l[1:0], a[3:0]} ^ 8'h3C;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	task automatic put_ent(input int l, input int b, input logic [7:0] a, input logic [7:0] d);
		wr_reg(PLT_CTRL_OFS, mk(1'b1, 1'b1, l[1:0], 1'b1, b[1:0], a, 1'b0, d));
	endtask

	task automatic get_ent(input int l, input int b, input logic [7:0] a, input logic [7:0] d);
		wr_reg(PLT_CTRL_OFS, mk(1'b1, 1'b0, l[1:0], 1'b0, b[1:0], a, 1'b0, 8'h00));
		rd_reg(PLT_CTRL_OFS, mk(1'b1, 1'b0, l[1:0], 1'b0, b[1:0], a, 1'b0, d));
	endtask

	// Output must appear one cycle after the pixel and then hold
	task automatic px(input logic [31:0] p, input logic [31:0] exp);
		src_u.send(p);
		#1;
		chk({31'h0, ovalid}, 32'h1);
		chk(odata, exp);
		@(posedge clk);
		#1;
		chk({31'h0, ovalid}, 32'h0);
		chk(odata, exp);
	endtask

	task automatic end_of_test();
		if (n_fail == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Whole run needs well under 1000 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			end_of_test();
		end
	end

	initial begin
		rst = 1'b1;
		cen = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		n_fail = 0;
		n_checks = 0;
		cyc = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd_reg(PLT_CTRL_OFS, 32'h0000_0000);
		wr_reg(8'h04, mk(1'b1, 1'b0, 2'h1, 1'b1, 2'h2, 8'h77, 1'b1, 8'h99));
		rd_reg(8'h04, 32'h0000_0000);
		rd_reg(PLT_CTRL_OFS, 32'h0000_0000);
		px(32'h0102_80FF, 32'h0102_80FF);
		for (int b = 0; b < 4; b++) begin
			for (int l = 0; l < 4; l++) begin
				for (int k = 0; k < 2; k++) begin
					put_ent(l, b, {8{k[0]}}, ent(l, b, {8{k[0]}}));
				end
			end
		end
		for (int b = 0; b < 4; b++) begin
			for (int l = 0; l < 4; l++) begin
				for (int k = 0; k < 2; k++) begin
					get_ent(l, b, {8{k[0]}}, ent(l, b, {8{k[0]}}));
				end
			end
		end
		wr_reg(PLT_CTRL_OFS, mk(1'b1, 1'b0, 2'h1, 1'b1, 2'h2, 8'hFF, 1'b0, 8'hEE));
		rd_reg(PLT_CTRL_OFS, mk(1'b1, 1'b0, 2'h1, 1'b1, 2'h2, 8'hFF, 1'b0, 8'hEE));
		get_ent(1, 2, 8'hFF, ent(1, 2, 8'hFF));
		wr_reg(PLT_CTRL_OFS, mk(1'b1, 1'b1, 2'h1, 1'b0, 2'h2, 8'hFF, 1'b0, 8'h44));
		get_ent(1, 2, 8'hFF, ent(1, 2, 8'hFF));
		wr_reg(PLT_CTRL_OFS, mk(1'b0, 1'b1, 2'h0, 1'b1, 2'h0, 8'h00, 1'b0, 8'h55));
		get_ent(0, 0, 8'h00, ent(0, 0, 8'h00));
		for (int b = 0; b < 4; b++) begin
			wr_reg(PLT_CTRL_OFS, mk(1'b0, 1'b0, 2'h0, 1'b0, b[1:0], 8'h00, 1'b1, 8'h00));
			rd_reg(PLT_CTRL_OFS, mk(1'b0, 1'b0, 2'h0, 1'b0, b[1:0], 8'h00, 1'b1, 8'h55));
			px(32'hFF00_FF00, {ent(3, b, 8'hFF), ent(2, b, 8'h00), ent(1, b, 8'hFF),
				ent(0, b, 8'h00)});
		end
		px(32'h5A5A_5A5A, 32'h0000_0000);
		wr_reg(PLT_CTRL_OFS, mk(1'b0, 1'b0, 2'h0, 1'b0, 2'h3, 8'h00, 1'b0, 8'h00));
		px(32'hFF00_FF00, 32'hFF00_FF00);
		// Frozen clock enable must swallow a full strobe write
		@(posedge clk);
		cen <= 1'b0;
		wr_reg(PLT_CTRL_OFS, mk(1'b1, 1'b1, 2'h2, 1'b1, 2'h1, 8'h11, 1'b1, 8'h66));
		cen <= 1'b1;
		rd_reg(PLT_CTRL_OFS, mk(1'b0, 1'b0, 2'h0, 1'b0, 2'h3, 8'h00, 1'b0, 8'h55));
		get_ent(2, 1, 8'h11, 8'h00);
		end_of_test();
	end
endmodule
`default_nettype wire
